/* rtl/input_mode_pkg.sv */
// Purpose: Shared constants and types for the analog input mode decoder
// Assumes: 8-bit control registers reached by serial subaddress
// Notes: All reset values are zero
package input_mode_pkg;

  // Subaddresses
  localparam logic [7:0] SUB_ANALOG_INPUT_CONTROL_ONE = 8'h02;
  localparam logic [7:0] SUB_GAIN_CONTROL = 8'h03;
  localparam logic [7:0] SUB_CHAN1_GAIN = 8'h04;
  localparam logic [7:0] SUB_CHAN2_GAIN = 8'h05;
  localparam logic [7:0] SUB_LUMA_CONTROL = 8'h09;

  // Reset values
  localparam logic [7:0] RST_ANALOG_INPUT_CONTROL_ONE = 8'h00;
  localparam logic [7:0] RST_GAIN_CONTROL = 8'h00;
  localparam logic [7:0] RST_CHAN_GAIN = 8'h00;
  localparam logic [7:0] RST_LUMA_CONTROL = 8'h00;

  // Field positions
  localparam int MODE_MSB = 5;
  localparam int MODE_LSB = 0;
  localparam int FUNC_SEL_MSB = 7;
  localparam int FUNC_SEL_LSB = 6;
  localparam int FIXED_GAIN_BIT = 2;
  localparam int CHAN2_SIGN_BIT = 1;
  localparam int CHAN1_SIGN_BIT = 0;
  localparam int LUMA_BYPASS_BIT = 7;

  // Serial link counts
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_READ_BIT = 4'h7;

  typedef enum logic [2:0] {
    MODE_CVBS = 3'b000,
    MODE_YC = 3'b001,
    MODE_COMPONENT = 3'b010,
    MODE_RGB = 3'b011,
    MODE_RESERVED = 3'b100
  } mode_class_e;

  typedef enum logic [2:0] {
    GAIN_OFF = 3'b000,
    GAIN_AGC = 3'b001,
    GAIN_STATIC1 = 3'b010,
    GAIN_STATIC2 = 3'b011,
    GAIN_FOLLOW_Y = 3'b100
  } gain_src_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_ACK_ADDR = 4'b0010,
    ST_SUB = 4'b0011,
    ST_ACK_SUB = 4'b0100,
    ST_WDATA = 4'b0101,
    ST_ACK_W = 4'b0110,
    ST_RDATA = 4'b0111,
    ST_RACK = 4'b1000
  } link_state_e;

endpackage

/* rtl/mode_route_if.sv */
// Purpose: Carries the mode field to the decoder and the routing back
// Assumes: Combinational decoder, registered by the consumer
// Notes: Channel index 0 is channel one
`timescale 1ns/1ps
interface mode_route_if;
  import input_mode_pkg::*;
  logic [5:0] mode;
  logic fixed_gain;
  mode_class_e mode_class;
  logic reserved;
  logic [1:0] in_num;
  logic [3:0] ch_en;
  gain_src_e [3:0] gain_src;

  modport decoder (
    input mode,
    input fixed_gain,
    output mode_class,
    output reserved,
    output in_num,
    output ch_en,
    output gain_src
  );

  modport ctrl (
    output mode,
    output fixed_gain,
    input mode_class,
    input reserved,
    input in_num,
    input ch_en,
    input gain_src
  );
endinterface

/* rtl/input_mode_decoder.sv */
// Purpose: Maps the six-bit input mode onto source selects and gain routing
// Assumes: Channel n takes inputs of group n
// Notes: Purely combinational
`timescale 1ns/1ps
module input_mode_decoder (
  mode_route_if.decoder rt
);
  import input_mode_pkg::*;

  logic [3:0] agc_ch;
  logic [3:0] c_ch;
  logic c_follow;
  logic [5:0] m;

  always_comb begin
    m = rt.mode;
    rt.mode_class = MODE_RESERVED;
    rt.reserved = 1'b0;
    rt.in_num = 2'b00;
    rt.ch_en = 4'h0;
    agc_ch = 4'h0;
    c_ch = 4'h0;
    c_follow = 1'b0;
    unique case (m)
      6'h00, 6'h01, 6'h0e, 6'h0f: begin
        rt.mode_class = MODE_CVBS;
        rt.in_num = {m[3], m[0]};
        rt.ch_en = 4'h1;
        agc_ch = 4'h1;
      end
      6'h02, 6'h03, 6'h04, 6'h05: begin
        rt.mode_class = MODE_CVBS;
        rt.in_num = 2'(m[1:0] - 2'b10);
        rt.ch_en = 4'h2;
        agc_ch = 4'h2;
      end
      6'h10, 6'h11, 6'h1e, 6'h1f: begin
        rt.mode_class = MODE_CVBS;
        rt.in_num = {m[3], m[0]};
        rt.ch_en = 4'h4;
        agc_ch = 4'h4;
      end
      6'h12, 6'h13, 6'h14, 6'h15: begin
        rt.mode_class = MODE_CVBS;
        rt.in_num = 2'(m[1:0] - 2'b10);
        rt.ch_en = 4'h8;
        agc_ch = 4'h8;
      end
      6'h06, 6'h07, 6'h0a, 6'h0b, 6'h08, 6'h09, 6'h0c, 6'h0d: begin
        rt.mode_class = MODE_YC;
        rt.in_num = {m[3] & (m[2] | m[1]), m[0]};
        rt.ch_en = 4'h3;
        agc_ch = 4'h1;
        c_ch = 4'h2;
        c_follow = m[3] & ~m[1];
      end
      6'h16, 6'h17, 6'h1a, 6'h1b, 6'h18, 6'h19, 6'h1c, 6'h1d: begin
        rt.mode_class = MODE_YC;
        rt.in_num = {m[3] & (m[2] | m[1]), m[0]};
        rt.ch_en = 4'hc;
        agc_ch = 4'h4;
        c_ch = 4'h8;
        c_follow = m[3] & ~m[1];
      end
      6'h20, 6'h21, 6'h2e, 6'h2f: begin
        rt.mode_class = MODE_COMPONENT;
        rt.in_num = {m[3], m[0]};
        rt.ch_en = 4'hf;
        agc_ch = 4'h1;
      end
      6'h30, 6'h31, 6'h3e, 6'h3f: begin
        rt.mode_class = MODE_RGB;
        rt.in_num = {m[3], m[0]};
        rt.ch_en = 4'hf;
        agc_ch = 4'h1;
      end
      default: begin
        rt.reserved = 1'b1;
      end
    endcase
  end

  // Per-channel gain source
  for (genvar ch = 0; ch < 4; ch++) begin : g_gain
    always_comb begin
      if (!rt.ch_en[ch]) begin
        rt.gain_src[ch] = GAIN_OFF;
      end else if (rt.fixed_gain) begin
        rt.gain_src[ch] = (ch % 2 == 0) ? GAIN_STATIC1 : GAIN_STATIC2;
      end else if (agc_ch[ch]) begin
        rt.gain_src[ch] = GAIN_AGC;
      end else if (c_ch[ch] && c_follow) begin
        rt.gain_src[ch] = GAIN_FOLLOW_Y;
      end else begin
        rt.gain_src[ch] = GAIN_STATIC2;
      end
    end
  end

endmodule // input_mode_decoder

/* rtl/analog_input_mode_ctrl.sv */
// Purpose: Serial-bus register slave and registered input routing
// Assumes: Host keeps the two-wire protocol; SCL far below clk rate
// Notes: Subaddress auto-increments after each data byte
`timescale 1ns/1ps
module analog_input_mode_ctrl
  import input_mode_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h21 // Arbitrary bus address
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Routing
  output logic [1:0] in_num,
  output logic [3:0] ch_en,
  output input_mode_pkg::gain_src_e [3:0] gain_src,
  output input_mode_pkg::mode_class_e mode_class,
  output logic mode_reserved,
  // Static settings
  output logic [1:0] analog_func_sel,
  output logic [8:0] chan1_static_gain,
  output logic [8:0] chan2_static_gain,
  output logic luma_bypass_full_band
);
  import input_mode_pkg::*;

  logic rst_meta_r, rst_n_r;
  logic [1:0] scl_sync_r, sda_sync_r;
  logic scl_d_r, sda_d_r;
  logic scl_s, sda_s, scl_rise, scl_fall, start_c, stop_c;

  link_state_e state_r, state_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] sub_r, sub_nxt;
  logic rw_r, rw_nxt;
  logic ack_r, ack_nxt;
  logic drive_r, drive_nxt;
  logic [7:0] analog_input_control_one_r, analog_input_control_one_nxt;
  logic [7:0] gctl_r, gctl_nxt;
  logic [7:0] gain1_r, gain1_nxt;
  logic [7:0] gain2_r, gain2_nxt;
  logic [7:0] luma_r, luma_nxt;
  logic [7:0] rd_data;

  mode_route_if rt ();

  input_mode_decoder u_dec (
    .rt(rt.decoder)
  );

  // Reset release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // Pins pass two flops; edges compare the second stage with its one-clock delayed copy
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      scl_sync_r <= 2'b11;
      sda_sync_r <= 2'b11;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      scl_d_r <= scl_sync_r[1];
      sda_d_r <= sda_sync_r[1];
    end
  end

  assign scl_s = scl_sync_r[1];
  assign sda_s = sda_sync_r[1];
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // Readback mirrors stored bytes
  always_comb begin
    unique case (sub_r)
      SUB_ANALOG_INPUT_CONTROL_ONE: rd_data = analog_input_control_one_r;
      SUB_GAIN_CONTROL: rd_data = gctl_r;
      SUB_CHAN1_GAIN: rd_data = gain1_r;
      SUB_CHAN2_GAIN: rd_data = gain2_r;
      SUB_LUMA_CONTROL: rd_data = luma_r;
      default: rd_data = 8'h00;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    bit_nxt = bit_r;
    shift_nxt = shift_r;
    sub_nxt = sub_r;
    rw_nxt = rw_r;
    ack_nxt = ack_r;
    drive_nxt = drive_r;
    analog_input_control_one_nxt = analog_input_control_one_r;
    gctl_nxt = gctl_r;
    gain1_nxt = gain1_r;
    gain2_nxt = gain2_r;
    luma_nxt = luma_r;
    if (start_c) begin
      state_nxt = ST_ADDR;
      bit_nxt = 4'h0;
      drive_nxt = 1'b0;
    end else if (stop_c) begin
      state_nxt = ST_IDLE;
      drive_nxt = 1'b0;
    end else if (scl_rise) begin
      if (state_r == ST_ADDR || state_r == ST_SUB || state_r == ST_WDATA) begin
        shift_nxt = {shift_r[6:0], sda_s};
        bit_nxt = 4'(bit_r + 4'h1);
      end else if (state_r == ST_RACK) begin
        ack_nxt = ~sda_s;
      end
    end else if (scl_fall) begin
      unique case (state_r)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (bit_r == BITS_PER_BYTE) begin
            if (shift_r[7:1] == DEV_ADDR) begin
              state_nxt = ST_ACK_ADDR;
              rw_nxt = shift_r[0];
              drive_nxt = 1'b1;
            end else begin
              state_nxt = ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR: begin
          bit_nxt = 4'h0;
          if (rw_r) begin
            state_nxt = ST_RDATA;
            shift_nxt = rd_data;
            drive_nxt = ~rd_data[7];
          end else begin
            state_nxt = ST_SUB;
            drive_nxt = 1'b0;
          end
        end
        ST_SUB: begin
          if (bit_r == BITS_PER_BYTE) begin
            sub_nxt = shift_r;
            state_nxt = ST_ACK_SUB;
            drive_nxt = 1'b1;
          end
        end
        ST_ACK_SUB, ST_ACK_W: begin
          state_nxt = ST_WDATA;
          bit_nxt = 4'h0;
          drive_nxt = 1'b0;
        end
        ST_WDATA: begin
          if (bit_r == BITS_PER_BYTE) begin
            unique case (sub_r)
              SUB_ANALOG_INPUT_CONTROL_ONE: analog_input_control_one_nxt = shift_r;
              SUB_GAIN_CONTROL: gctl_nxt = shift_r;
              SUB_CHAN1_GAIN: gain1_nxt = shift_r;
              SUB_CHAN2_GAIN: gain2_nxt = shift_r;
              SUB_LUMA_CONTROL: luma_nxt = shift_r;
              default: begin
              end
            endcase
            sub_nxt = 8'(sub_r + 8'h01);
            state_nxt = ST_ACK_W;
            drive_nxt = 1'b1;
          end
        end
        ST_RDATA: begin
          if (bit_r == LAST_READ_BIT) begin
            state_nxt = ST_RACK;
            drive_nxt = 1'b0;
            sub_nxt = 8'(sub_r + 8'h01);
          end else begin
            bit_nxt = 4'(bit_r + 4'h1);
            shift_nxt = {shift_r[6:0], 1'b0};
            drive_nxt = ~shift_r[6];
          end
        end
        ST_RACK: begin
          // A missing acknowledge ends the read burst
          if (ack_r) begin
            state_nxt = ST_RDATA;
            bit_nxt = 4'h0;
            shift_nxt = rd_data;
            drive_nxt = ~rd_data[7];
          end else begin
            state_nxt = ST_IDLE;
            drive_nxt = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_IDLE;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      sub_r <= 8'h00;
      rw_r <= 1'b0;
      ack_r <= 1'b0;
      drive_r <= 1'b0;
      analog_input_control_one_r <= RST_ANALOG_INPUT_CONTROL_ONE;
      gctl_r <= RST_GAIN_CONTROL;
      gain1_r <= RST_CHAN_GAIN;
      gain2_r <= RST_CHAN_GAIN;
      luma_r <= RST_LUMA_CONTROL;
    end else begin
      state_r <= state_nxt;
      bit_r <= bit_nxt;
      shift_r <= shift_nxt;
      sub_r <= sub_nxt;
      rw_r <= rw_nxt;
      ack_r <= ack_nxt;
      drive_r <= drive_nxt;
      analog_input_control_one_r <= analog_input_control_one_nxt;
      gctl_r <= gctl_nxt;
      gain1_r <= gain1_nxt;
      gain2_r <= gain2_nxt;
      luma_r <= luma_nxt;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_r;

  assign rt.mode = analog_input_control_one_r[MODE_MSB:MODE_LSB];
  assign rt.fixed_gain = gctl_r[FIXED_GAIN_BIT];

  // Routing registered so a mode change lands glitch-free
  always_ff @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      in_num <= 2'b00;
      ch_en <= 4'h0;
      gain_src <= '{GAIN_OFF, GAIN_OFF, GAIN_OFF, GAIN_OFF};
      mode_class <= MODE_CVBS;
      mode_reserved <= 1'b0;
    end else begin
      in_num <= rt.in_num;
      ch_en <= rt.ch_en;
      gain_src <= rt.gain_src;
      mode_class <= rt.mode_class;
      mode_reserved <= rt.reserved;
    end
  end

  assign analog_func_sel = analog_input_control_one_r[FUNC_SEL_MSB:FUNC_SEL_LSB];
  assign chan1_static_gain = {gctl_r[CHAN1_SIGN_BIT], gain1_r};
  assign chan2_static_gain = {gctl_r[CHAN2_SIGN_BIT], gain2_r};
  assign luma_bypass_full_band = luma_r[LUMA_BYPASS_BIT];

endmodule // analog_input_mode_ctrl

/* testbench/analog_input_mode_ctrl_props.sv */
// Purpose: Port checks for the input mode controller
// Assumes: Host bus phases of at least ten clocks
// Notes: Bound to every controller instance
`timescale 1ns/1ps
module analog_input_mode_ctrl_props
  import input_mode_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Watched outputs
  input wire logic sda_oe_n,
  input wire logic [1:0] in_num,
  input wire logic [3:0] ch_en,
  input wire input_mode_pkg::gain_src_e [3:0] gain_src,
  input wire input_mode_pkg::mode_class_e mode_class,
  input wire logic mode_reserved,
  input wire logic [1:0] analog_func_sel
);
  logic [3:0] up_r;
  logic [3:0] up_nxt;

  // Routing loads mode 00 just after release, so wait before judging
  always_comb begin
    up_nxt = (up_r == 4'h8) ? up_r : up_r + 4'h1;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      up_r <= 4'h0;
    end else begin
      up_r <= up_nxt;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  chk_reserved_class: assert property (
    mode_reserved == (mode_class == MODE_RESERVED))
    else $error("reserved flag and class disagree");
  chk_rgb_all_groups: assert property (
    mode_class == MODE_RGB |-> ch_en == 4'hf &&
    gain_src[0] inside {GAIN_AGC, GAIN_STATIC1})
    else $error("rgb routing wrong");
  chk_comp_all_groups: assert property (
    mode_class == MODE_COMPONENT |-> ch_en == 4'hf &&
    gain_src[0] inside {GAIN_AGC, GAIN_STATIC1})
    else $error("component routing wrong");
  chk_cvbs_one_chan: assert property (
    up_r == 4'h8 && mode_class == MODE_CVBS |-> $onehot(ch_en))
    else $error("composite mode not on one channel");
  chk_yc_chan_pair: assert property (
    mode_class == MODE_YC |-> ch_en inside {4'h3, 4'hc})
    else $error("luma chroma pair wrong");
  chk_yc_chroma_gain: assert property (
    mode_class == MODE_YC && ch_en == 4'hc |->
    gain_src[3] inside {GAIN_STATIC2, GAIN_FOLLOW_Y})
    else $error("chroma gain source wrong");
  chk_idle_chan_off: assert property (
    up_r == 4'h8 && !mode_reserved |->
    (ch_en[1] || gain_src[1] == GAIN_OFF) &&
    (ch_en[3] || gain_src[3] == GAIN_OFF))
    else $error("disabled channel has gain");
  chk_route_by_write: assert property (
    up_r == 4'h8 && !$stable({in_num, ch_en, mode_class})
    |-> ##[0:6] !sda_oe_n)
    else $error("routing moved without a write");
  chk_func_by_write: assert property (
    $changed(analog_func_sel) |-> ##[0:6] !sda_oe_n)
    else $error("function select moved without a write");
  chk_drive_holds: assert property (
    $fell(sda_oe_n) |-> !sda_oe_n [*8])
    else $error("data line drive too short");

  cov_rgb: cover property (mode_class == MODE_RGB);
  cov_yc: cover property (mode_class == MODE_YC);
  cov_reserved: cover property (mode_reserved);
  cov_ack: cover property ($fell(sda_oe_n));
endmodule // analog_input_mode_ctrl_props

bind analog_input_mode_ctrl analog_input_mode_ctrl_props u_props (
  .clk(clk), .arst_n(arst_n), .sda_oe_n(sda_oe_n), .in_num(in_num),
  .ch_en(ch_en), .gain_src(gain_src), .mode_class(mode_class),
  .mode_reserved(mode_reserved), .analog_func_sel(analog_func_sel)
);

/* testbench/serial_host_model.sv */
// Purpose: Two-wire bus host that programs the controller
// Assumes: Ten clock phases, well above the device minimum
// Notes: Open drain; pull set means the host pulls the line low
`timescale 1ns/1ps
module serial_host_model (
  // Clock
  input wire logic clk,
  // Bus pins
  output logic scl,
  output logic sda_pull,
  input wire logic sda,
  // Read results
  output logic [7:0] rd_data,
  output logic rd_stb
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    rd_data = 8'h00;
    rd_stb = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Extra clocks after the fall keep data edges clear of the clock edge
  task automatic bit_io(input logic b, output logic r);
    sda_pull = !b;
    tick(10);
    scl = 1'b1;
    tick(5);
    r = sda;
    tick(5);
    scl = 1'b0;
    tick(3);
  endtask

  task automatic byte_io(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r[i]);
    end
  endtask

  task automatic start();
    sda_pull = 1'b0;
    tick(5);
    scl = 1'b1;
    tick(10);
    sda_pull = 1'b1;
    tick(10);
    scl = 1'b0;
    tick(3);
  endtask

  task automatic stop();
    sda_pull = 1'b1;
    tick(5);
    scl = 1'b1;
    tick(10);
    sda_pull = 1'b0;
    tick(10);
  endtask

  task automatic send(input logic [7:0] b, inout logic nack);
    logic [7:0] r;
    logic a;
    byte_io(b, r);
    bit_io(1'b1, a);
    nack = nack | a;
  endtask

  // Two data bytes: the second lands at the next subaddress
  task automatic write_regs(input logic [6:0] a, input logic [7:0] sub,
      input logic [15:0] d, output logic nack);
    nack = 1'b0;
    start();
    send({a, 1'b0}, nack);
    send(sub, nack);
    send(d[15:8], nack);
    send(d[7:0], nack);
    stop();
  endtask

  task automatic read_regs(input logic [6:0] a, input logic [7:0] sub);
    logic nack;
    logic d;
    nack = 1'b0;
    start();
    send({a, 1'b0}, nack);
    send(sub, nack);
    start();
    send({a, 1'b1}, nack);
    for (int i = 0; i < 2; i++) begin
      byte_io(8'hff, rd_data);
      bit_io(i == 1, d);
      rd_stb = 1'b1;
      tick(1);
      rd_stb = 1'b0;
    end
    stop();
  endtask
endmodule // serial_host_model

/* testbench/tb.sv */
// Purpose: Self-checking bench for the input mode controller
// Assumes: Default device address 21h
// Notes: Every mode code is written once
`timescale 1ns/1ps
module tb;
  import input_mode_pkg::*;
  localparam logic [6:0] DEV = 7'h21;
  logic clk, arst_n, scl, sda_pull, sda, sda_out, sda_oe_n, rd_stb;
  logic mode_reserved, luma_bypass_full_band;
  logic [7:0] rd_data;
  logic [1:0] in_num, analog_func_sel;
  logic [3:0] ch_en;
  logic [8:0] chan1_static_gain, chan2_static_gain;
  gain_src_e [3:0] gain_src;
  mode_class_e mode_class;
  int error_cnt = 0;
  int checks_done = 0;
  int seed = 54305;
  logic [7:0] exp_q[$];
  logic [21:0] got;

  assign sda = !sda_pull && (sda_oe_n || sda_out);
  assign got = {mode_class, mode_reserved, in_num, ch_en, gain_src};

  analog_input_mode_ctrl #(.DEV_ADDR(DEV)) u_analog_input_mode_ctrl (
    .clk(clk), .arst_n(arst_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .in_num(in_num),
    .ch_en(ch_en), .gain_src(gain_src), .mode_class(mode_class),
    .mode_reserved(mode_reserved), .analog_func_sel(analog_func_sel),
    .chan1_static_gain(chan1_static_gain),
    .chan2_static_gain(chan2_static_gain),
    .luma_bypass_full_band(luma_bypass_full_band));
  serial_host_model u_serial_host_model (
    .clk(clk), .scl(scl), .sda_pull(sda_pull), .sda(sda),
    .rd_data(rd_data), .rd_stb(rd_stb));

  task automatic check(input logic [21:0] a, input logic [21:0] e);
    checks_done++;
    if (a !== e) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, a, e);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  function automatic logic [21:0] route_of(input logic [5:0] m,
      input logic fx);
    mode_class_e c;
    gain_src_e [3:0] gs;
    logic rs;
    logic [1:0] n;
    logic [3:0] e, lo;
    int y;
    lo = m[3:0];
    rs = 1'b0;
    y = m[4] ? 2 : 0;
    for (int k = 0; k < 4; k++) begin
      gs[k] = GAIN_OFF;
    end
    if (m[5]) begin
      c = m[4] ? MODE_RGB : MODE_COMPONENT;
      rs = !(lo inside {4'h0, 4'h1, 4'he, 4'hf});
      if (rs) begin
        c = MODE_RESERVED;
      end
      n = lo[1:0];
      e = 4'hf;
      gs = '{GAIN_STATIC2, GAIN_STATIC2, GAIN_STATIC2, GAIN_AGC};
    end else if (lo inside {[4'h6:4'hd]}) begin
      c = MODE_YC;
      n = {lo >= 4'ha, lo[0]};
      e = m[4] ? 4'hc : 4'h3;
      gs[y] = GAIN_AGC;
      gs[y + 1] = lo[1] ? GAIN_STATIC2 : GAIN_FOLLOW_Y;
    end else begin
      c = MODE_CVBS;
      n = (lo inside {[4'h2:4'h5]}) ? lo[1:0] - 2'h2 : lo[1:0];
      y = y + ((lo inside {[4'h2:4'h5]}) ? 1 : 0);
      e = 4'h1 << y;
      gs[y] = GAIN_AGC;
    end
    for (int k = 0; k < 4; k++) begin
      if (fx && e[k]) begin
        gs[k] = k[0] ? GAIN_STATIC2 : GAIN_STATIC1;
      end
    end
    return {c, rs, n, e, gs};
  endfunction

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Run needs about 70k clocks; give up at 100k
  initial begin
    #2500us;
    error_cnt++;
    finish_test();
  end

  always @(posedge clk) begin
    if (rd_stb === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(22'h1, 22'h0);
      end else begin
        check(22'(rd_data), 22'(exp_q.pop_front()));
      end
    end
  end

  initial begin
    logic nack;
    logic fx;
    logic [7:0] r;
    logic [15:0] d;
    logic [21:0] ex, msk;
    arst_n = 1'b0;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    repeat (6) @(negedge clk);
    check(got, route_of(6'h00, 1'b0));
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h00);
    u_serial_host_model.read_regs(DEV, 8'h02);
    for (int m = 0; m < 64; m++) begin
      r = 8'($random(seed));
      ex = route_of(m[5:0], 1'b0);
      // Even composite codes act as digitizer codes with fixed gain;
      // odd ones keep auto gain so that path is exercised too
      fx = (ex[21:19] == MODE_CVBS) ? ~m[0] : r[2];
      d = {r[7:6], m[5:0], 5'h00, fx, r[1:0]};
      u_serial_host_model.write_regs(DEV, 8'h02, d, nack);
      check(22'(nack), 22'h0);
      ex = route_of(m[5:0], fx);
      msk = ex[18] ? 22'h3c0000 : 22'h3fffff;
      check(got & msk, ex & msk);
      check(22'({analog_func_sel, chan1_static_gain[8],
            chan2_static_gain[8]}), 22'({r[7:6], r[0], r[1]}));
      if (m % 8 == 3) begin
        exp_q.push_back(d[15:8]);
        exp_q.push_back(d[7:0]);
        u_serial_host_model.read_regs(DEV, 8'h02);
      end
    end
    u_serial_host_model.write_regs(DEV + 7'h1, 8'h02, 16'h2000, nack);
    check({21'(got), nack}, {21'(ex), 1'b1});
    // Host sets luma bypass; the byte after it hits an unmapped place
    u_serial_host_model.write_regs(DEV, 8'h09, 16'h80ff, nack);
    check(22'(luma_bypass_full_band), 22'h1);
    exp_q.push_back(8'h80);
    exp_q.push_back(8'h00);
    u_serial_host_model.read_regs(DEV, 8'h09);
    // Static gain bytes reach the gain outputs untouched
    r = 8'($random(seed));
    d = {r, ~r};
    u_serial_host_model.write_regs(DEV, 8'h04, d, nack);
    check(22'({chan1_static_gain[7:0], chan2_static_gain[7:0]}),
          22'(d));
    check(22'({sda_out, nack}), 22'h0);
    repeat (5) @(negedge clk);
    check(22'(exp_q.size()), 22'h0);
    finish_test();
  end
endmodule // tb
